// ---- verilog/pplf_regs.sv ----
// Per-phase current limit and switching frequency register bank
//
// Overview of operation
// - Phase entering limit sets its flag
// - Phase eight bit 7, phase one bit 0
// - Threshold is 200 mV plus 50 mV per code
// - Host writes 5-bit threshold in bits 4:0
// - Register threshold used only when selected
// - Otherwise resistor threshold tracked continuously
// - Bit 5 picks 100k or 50k sense
// - Power-on captures even frequency resistor code
// - Host frequency applies only when selected
// - Frequency config 5-bit code, bits 7:5 reserved
// - Frequency per code depends on phase count
// - Equal bytes in both latches switch source
`timescale 1ns/1ns
module pplf_regs #(
    parameter int PHASES = 8
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    input  wire pplf_pkg::pplf_req_s req,
    input  wire logic [PHASES-1:0]   phase_in_limit,
    input  wire logic [4:0]          limit_resistor_code,
    input  wire logic [4:0]          frequency_setting_pin_code,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    output logic [4:0]               limit_code_eff,
    output logic [10:0]              limit_mv,
    output logic                     rcur_50k,
    output logic [4:0]               freq_code_eff,
    output logic [11:0]              freq_khz_8ph,
    output logic                     limit_from_reg,
    output logic                     freq_from_reg
);
    logic [PHASES-1:0] limit_sync;         // Synchronised per-phase limit levels
    logic [PHASES-1:0] limit_prev_reg;     // Previous level for entry detection
    logic [7:0]        limit_stat_reg;     // Sticky per-phase flags
    logic [4:0]        limit_thr_reg;      // Host threshold code
    logic              rcur_sel_reg;       // Sense resistance select
    logic [4:0]        freq_stat_reg;      // Captured frequency code
    logic [4:0]        freq_cfg_reg;       // Host frequency code
    logic              captured_reg;       // Power-on capture done
    logic [7:0]        latch_a_reg;        // Pending latch byte A
    logic [7:0]        latch_b_reg;        // Pending latch byte B
    logic [7:0]        sel_reg;            // Committed source selection
    logic [PHASES-1:0] entry;              // Rising limit entries
    logic [7:0]        entry_byte;         // Entries placed in the status byte
    logic              stat_read;          // Status read clears flags
    logic [4:0]        limit_next;         // Next effective threshold
    logic [4:0]        freq_next;          // Next effective frequency code

    // Threshold code to millivolts
    function automatic logic [10:0] code_to_mv(input logic [4:0] code);
        logic [10:0] steps;
        steps = 11'(code) * pplf_pkg::PPLF_LIMIT_STEP_MV;
        return pplf_pkg::PPLF_LIMIT_BASE_MV + steps;
    endfunction

    // Frequency step in kHz at eight phases; other phase counts are scaled by the modulator
    function automatic logic [11:0] code_to_khz8(input logic [4:0] code);
        logic [11:0] khz;
        case (code)
            5'h00:   khz = 12'd221;
            5'h01:   khz = 12'd244;
            5'h02:   khz = 12'd266;
            5'h03:   khz = 12'd293;
            5'h04:   khz = 12'd307;
            5'h05:   khz = 12'd333;
            5'h06:   khz = 12'd351;
            5'h07:   khz = 12'd373;
            5'h08:   khz = 12'd394;
            5'h09:   khz = 12'd421;
            5'h0a:   khz = 12'd449;
            5'h0b:   khz = 12'd469;
            5'h0c:   khz = 12'd479;
            5'h0d:   khz = 12'd509;
            5'h0e:   khz = 12'd518;
            5'h0f:   khz = 12'd543;
            5'h10:   khz = 12'd581;
            5'h11:   khz = 12'd649;
            5'h12:   khz = 12'd708;
            5'h13:   khz = 12'd751;
            5'h14:   khz = 12'd799;
            5'h15:   khz = 12'd866;
            5'h16:   khz = 12'd919;
            5'h17:   khz = 12'd964;
            5'h18:   khz = 12'd993;
            5'h19:   khz = 12'd1059;
            5'h1a:   khz = 12'd1098;
            5'h1b:   khz = 12'd1141;
            5'h1c:   khz = 12'd1200;
            5'h1d:   khz = 12'd1236;
            5'h1e:   khz = 12'd1291;
            default: khz = 12'd1312;
        endcase
        return khz;
    endfunction

    // Limit comparator outputs come from the analog side
    pplf_sync #(
        .WIDTH (PHASES)
    ) u_limit_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .async_in (phase_in_limit),
        .sync_out (limit_sync)
    );

    // Entry detection and selection muxes
    always_comb begin
        entry      = limit_sync & ~limit_prev_reg;
        entry_byte = 8'h00;
        entry_byte[PHASES-1:0] = entry;
        stat_read  = req.rd && (req.addr == pplf_pkg::PPLF_OFS_LIMIT_STAT);
        limit_next = sel_reg[pplf_pkg::PPLF_SEL_LIMIT] ? limit_thr_reg : limit_resistor_code;
        freq_next  = sel_reg[pplf_pkg::PPLF_SEL_FREQ] ? freq_cfg_reg : freq_stat_reg;
    end

    // Sticky limit flags, cleared by reading; a new entry beats the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limit_prev_reg <= '0;
            limit_stat_reg <= pplf_pkg::PPLF_RST_BYTE;
        end else if (ce) begin
            limit_prev_reg <= limit_sync;
            limit_stat_reg <= (stat_read ? 8'h00 : limit_stat_reg) | entry_byte;
        end
    end

    // Host-written configuration
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limit_thr_reg <= 5'h00;
            rcur_sel_reg  <= 1'b0;
            freq_cfg_reg  <= 5'h00;
        end else if (ce && req.wr) begin
            if (req.addr == pplf_pkg::PPLF_OFS_LIMIT_CFG) begin
                limit_thr_reg <= req.wdata[4:0];
                rcur_sel_reg  <= req.wdata[pplf_pkg::PPLF_RCUR_BIT];
            end
            if (req.addr == pplf_pkg::PPLF_OFS_FREQ_CFG) begin
                freq_cfg_reg <= req.wdata[4:0];
            end
        end
    end

    // Power-on capture of the frequency resistor, taken after reset release not during it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            freq_stat_reg <= 5'h00;
            captured_reg  <= 1'b0;
        end else if (ce && !captured_reg) begin
            freq_stat_reg <= {frequency_setting_pin_code[4:1], 1'b0};
            captured_reg  <= 1'b1;
        end
    end

    // Second-function latches; a write commits when both bytes match
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            latch_a_reg <= pplf_pkg::PPLF_RST_BYTE;
            latch_b_reg <= pplf_pkg::PPLF_RST_BYTE;
            sel_reg     <= pplf_pkg::PPLF_RST_BYTE;
        end else if (ce && req.wr) begin
            if (req.addr == pplf_pkg::PPLF_OFS_LATCH_A) begin
                latch_a_reg <= req.wdata;
                if (req.wdata == latch_b_reg) begin
                    sel_reg <= req.wdata;
                end
            end
            if (req.addr == pplf_pkg::PPLF_OFS_LATCH_B) begin
                latch_b_reg <= req.wdata;
                if (req.wdata == latch_a_reg) begin
                    sel_reg <= req.wdata;
                end
            end
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data  <= pplf_pkg::PPLF_NO_REG;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    pplf_pkg::PPLF_OFS_LIMIT_STAT: rd_data <= limit_stat_reg;
                    pplf_pkg::PPLF_OFS_LIMIT_CFG:  rd_data <= {2'b00, rcur_sel_reg, limit_thr_reg};
                    pplf_pkg::PPLF_OFS_FREQ_STAT:  rd_data <= {3'b000, freq_stat_reg};
                    pplf_pkg::PPLF_OFS_FREQ_CFG:   rd_data <= {3'b000, freq_cfg_reg};
                    pplf_pkg::PPLF_OFS_LATCH_A:    rd_data <= latch_a_reg;
                    pplf_pkg::PPLF_OFS_LATCH_B:    rd_data <= latch_b_reg;
                    default:                       rd_data <= pplf_pkg::PPLF_NO_REG;
                endcase
            end
        end
    end

    // Effective settings to the analog and modulator side
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limit_code_eff <= 5'h00;
            limit_mv       <= pplf_pkg::PPLF_LIMIT_BASE_MV;
            rcur_50k       <= 1'b0;
            freq_code_eff  <= 5'h00;
            freq_khz_8ph   <= 12'd221;
            limit_from_reg <= 1'b0;
            freq_from_reg  <= 1'b0;
        end else if (ce) begin
            limit_code_eff <= limit_next;
            limit_mv       <= code_to_mv(limit_next);
            rcur_50k       <= rcur_sel_reg;
            freq_code_eff  <= freq_next;
            freq_khz_8ph   <= code_to_khz8(freq_next);
            limit_from_reg <= sel_reg[pplf_pkg::PPLF_SEL_LIMIT];
            freq_from_reg  <= sel_reg[pplf_pkg::PPLF_SEL_FREQ];
        end
    end
endmodule

// ---- verilog/pplf_pkg.sv ----
// Package with offsets, field layouts, reset values and types of the limit and frequency register bank
package pplf_pkg;
    // Register offsets on the host register port
    localparam logic [7:0] PPLF_OFS_LIMIT_STAT = 8'h2d;  // Per-phase limit status
    localparam logic [7:0] PPLF_OFS_LIMIT_CFG  = 8'h2e;  // Limit threshold and sense select
    localparam logic [7:0] PPLF_OFS_FREQ_STAT  = 8'h2f;  // Captured frequency code
    localparam logic [7:0] PPLF_OFS_FREQ_CFG   = 8'h30;  // Host frequency code
    localparam logic [7:0] PPLF_OFS_LATCH_A    = 8'h46;  // Second-function latch A
    localparam logic [7:0] PPLF_OFS_LATCH_B    = 8'h47;  // Second-function latch B

    // Field positions
    localparam int PPLF_CODE_W      = 5;   // Threshold and frequency code width
    localparam int PPLF_RCUR_BIT    = 5;   // Sense resistance select bit
    localparam int PPLF_SEL_FREQ    = 0;   // Latch bit: frequency from register
    localparam int PPLF_SEL_LIMIT   = 2;   // Latch bit: limit threshold from register

    // Reset values
    localparam logic [7:0] PPLF_RST_BYTE  = 8'h00;  // All registers and latches
    localparam logic [7:0] PPLF_NO_REG    = 8'h00;  // Answer for unmapped offsets

    // Threshold scale in millivolts
    localparam logic [10:0] PPLF_LIMIT_BASE_MV = 11'h0c8;  // 200 mV at code 0
    localparam logic [10:0] PPLF_LIMIT_STEP_MV = 11'h032;  // 50 mV per code

    // One access from the host interface engine
    typedef struct packed {
        logic       wr;     // Write strobe, one cycle
        logic       rd;     // Read strobe, one cycle
        logic [7:0] addr;   // Register offset
        logic [7:0] wdata;  // Write byte
    } pplf_req_s;
endpackage

// ---- verilog/pplf_sync.sv ----
// Three-stage input synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ns
module pplf_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] st1_reg;  // Metastability catcher, read only by st2
    logic [WIDTH-1:0] st2_reg;  // Second stage
    logic [WIDTH-1:0] st3_reg;  // Third stage

    // Shift chain
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st1_reg <= '0;
            st2_reg <= '0;
            st3_reg <= '0;
        end else if (ce) begin
            st1_reg <= async_in;
            st2_reg <= st1_reg;
            st3_reg <= st2_reg;
        end
    end

    // Accept bitwise only where stages two and three agree, filtering single-cycle glitches
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_out <= '0;
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (st2_reg[i] == st3_reg[i]) begin
                    sync_out[i] <= st3_reg[i];
                end
            end
        end
    end
endmodule

// ---- dv/pplf_regs_properties.sv ----
// Port checker for the limit and frequency register bank
`timescale 1ns/1ns
module pplf_regs_properties #(
    parameter int PHASES = 8
) (
    input wire logic                core_clk,
    input wire logic                rstn,
    input wire logic                ce,
    input wire pplf_pkg::pplf_req_s req,
    input wire logic [PHASES-1:0]   phase_in_limit,
    input wire logic [4:0]          limit_resistor_code,
    input wire logic [7:0]          rd_data,
    input wire logic                rd_valid,
    input wire logic [4:0]          limit_code_eff,
    input wire logic [10:0]         limit_mv,
    input wire logic                rcur_50k,
    input wire logic [4:0]          freq_code_eff,
    input wire logic [11:0]         freq_khz_8ph,
    input wire logic                freq_from_reg,
    input wire logic                limit_from_reg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Quiet spell: limit levels steady, no status read
    sequence s_quiet;
        (ce && $stable(phase_in_limit) && !(req.rd && req.addr == 8'h2d))[*7];
    endsequence
    // Status read eight edges after a fresh entry
    sequence s_stat_rd;
        ce && req.rd && req.addr == 8'h2d && $past(phase_in_limit, 9) == '0;
    endsequence
    property p_stat_set;
        s_quiet ##1 s_stat_rd |=> (rd_data[PHASES-1:0] & $past(phase_in_limit, 2)) == $past(phase_in_limit, 2);
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("limit flag missing");
    property p_rd_answer;
        ce |=> rd_valid == $past(req.rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_mv;
        $stable(limit_code_eff)[*2] |-> limit_mv == pplf_pkg::PPLF_LIMIT_BASE_MV + 11'h032 * limit_code_eff;
    endproperty
    a_mv: assert property (p_mv) else $error("threshold scale wrong");
    property p_lim_res;
        (ce && !limit_from_reg && $stable(limit_resistor_code))[*4] |-> limit_code_eff == limit_resistor_code;
    endproperty
    a_lim_res: assert property (p_lim_res) else $error("resistor threshold not tracked");
    property p_rcur;
        ce && req.wr && req.addr == 8'h2e ##1 ce |=> rcur_50k == $past(req.wdata[5], 2);
    endproperty
    a_rcur: assert property (p_rcur) else $error("sense select wrong");
    property p_freq_even;
        (ce && !freq_from_reg)[*4] |-> !freq_code_eff[0];
    endproperty
    a_freq_even: assert property (p_freq_even) else $error("captured code odd");
    property p_khz_lo;
        (freq_code_eff == 5'h00)[*2] |-> freq_khz_8ph == 12'h0dd;
    endproperty
    a_khz_lo: assert property (p_khz_lo) else $error("lowest frequency wrong");
    property p_khz_hi;
        (freq_code_eff == 5'h1f)[*2] |-> freq_khz_8ph == 12'h520;
    endproperty
    a_khz_hi: assert property (p_khz_hi) else $error("highest frequency wrong");
    property p_rsv;
        ce && req.rd && req.addr == 8'h30 |=> rd_data[7:5] == 3'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind pplf_regs pplf_regs_properties #(.PHASES(PHASES)) chk_u (.core_clk(core_clk), .rstn(rstn), .ce(ce), .req(req),
    .phase_in_limit(phase_in_limit), .limit_resistor_code(limit_resistor_code), .rd_data(rd_data),
    .rd_valid(rd_valid), .limit_code_eff(limit_code_eff), .limit_mv(limit_mv), .rcur_50k(rcur_50k),
    .freq_code_eff(freq_code_eff), .freq_khz_8ph(freq_khz_8ph), .freq_from_reg(freq_from_reg),
    .limit_from_reg(limit_from_reg));

// ---- dv/pplf_host_model.sv ----
// Host model issuing register accesses on the request port
`timescale 1ns/1ns
module pplf_host_model (
    input  wire logic          core_clk,
    input  wire logic [7:0]    rd_data,
    input  wire logic          rd_valid,
    output pplf_pkg::pplf_req_s req
);
    initial req = '0;
    // One write strobe; idle lines show inverted data, not stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // One read strobe; answer is due one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        req = '{1'b0, 1'b0, ~a, 8'hff};
        d = rd_valid ? rd_data : 8'hxx;
    endtask
endmodule

// ---- dv/pplf_regs_tb_top.sv ----
// Self-checking bench for the limit and frequency register bank
`timescale 1ns/1ns
module pplf_regs_tb_top;
    logic                core_clk = 1'b0;  // 25 MHz core clock
    logic                rstn     = 1'b0;  // Active-low reset
    logic                ce       = 1'b1;  // Clock enable
    logic [7:0]          lim_in   = 8'h00; // Phase limit levels
    logic [4:0]          res_code = 5'h07; // Limit resistor code
    logic [4:0]          pin_code = 5'h1b; // Odd on purpose: capture must drop bit 0
    pplf_pkg::pplf_req_s req;
    logic [7:0]          rd_data;
    logic                rd_valid, rcur_50k, limit_from_reg, freq_from_reg;
    logic [4:0]          limit_code_eff, freq_code_eff;
    logic [10:0]         limit_mv;
    logic [11:0]         freq_khz_8ph;
    int                  n_mismatch = 0;
    int                  n_compared = 0;
    always #20 core_clk = ~core_clk;
    pplf_host_model host_u (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
    pplf_regs #(.PHASES(8)) dut_u (.core_clk(core_clk), .rstn(rstn), .ce(ce), .req(req),
        .phase_in_limit(lim_in), .limit_resistor_code(res_code), .frequency_setting_pin_code(pin_code),
        .rd_data(rd_data), .rd_valid(rd_valid), .limit_code_eff(limit_code_eff), .limit_mv(limit_mv),
        .rcur_50k(rcur_50k), .freq_code_eff(freq_code_eff), .freq_khz_8ph(freq_khz_8ph),
        .limit_from_reg(limit_from_reg), .freq_from_reg(freq_from_reg));
    // Compare one value
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read a register and compare the byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk("read byte", {4'h0, exp}, {4'h0, d});
    endtask
    // Values straight after reset
    task automatic t_power_on();
        rchk(8'h2f, 8'h1a);
        rchk(8'h2e, 8'h00);
        rchk(8'h30, 8'h00);
        host_u.wr(8'h55, 8'hff);
        rchk(8'h55, 8'h00);
        chk("limit code", {7'h0, res_code}, {7'h0, limit_code_eff});
        chk("freq khz", 12'h44a, freq_khz_8ph);
    endtask
    // Host settings, before and after the source switch
    task automatic t_config();
        host_u.wr(8'h2e, 8'hff);
        host_u.wr(8'h30, 8'hff);
        host_u.wr(8'h2f, 8'h00);
        rchk(8'h2e, 8'h3f);
        rchk(8'h30, 8'h1f);
        rchk(8'h2f, 8'h1a);
        chk("sense select", 12'h001, {11'h0, rcur_50k});
        chk("limit code", {7'h0, res_code}, {7'h0, limit_code_eff});
        chk("freq code", 12'h01a, {7'h0, freq_code_eff});
        host_u.wr(8'h46, 8'h05);
        host_u.wr(8'h47, 8'h05);
        repeat (3) @(negedge core_clk);
        chk("limit from reg", 12'h001, {11'h0, limit_from_reg});
        chk("freq from reg", 12'h001, {11'h0, freq_from_reg});
        chk("limit mv", 12'h6d6, {1'b0, limit_mv});
        chk("freq khz", 12'h520, freq_khz_8ph);
        host_u.wr(8'h2e, 8'h01);
        host_u.wr(8'h30, 8'h00);
        repeat (3) @(negedge core_clk);
        chk("limit mv", 12'h0fa, {1'b0, limit_mv});
        chk("freq khz", 12'h0dd, freq_khz_8ph);
        host_u.wr(8'h47, 8'h00);
        host_u.wr(8'h46, 8'h00);
        res_code = 5'h03;
        repeat (6) @(negedge core_clk);
        chk("limit mv", 12'h15e, {1'b0, limit_mv});
        chk("freq code", 12'h01a, {7'h0, freq_code_eff});
    endtask
    // Sticky per-phase flags; a steady level sets them only once
    task automatic t_status();
        lim_in = 8'h81;
        repeat (7) @(negedge core_clk);
        rchk(8'h2d, 8'h81);
        rchk(8'h2d, 8'h00);
        lim_in = 8'h7e;
        repeat (7) @(negedge core_clk);
        rchk(8'h2d, 8'h7e);
    endtask
    // Clock enable low: strobes ignored, effective outputs frozen
    task automatic t_freeze();
        ce       = 1'b0;
        res_code = 5'h09;
        host_u.wr(8'h2e, 8'h3f);
        repeat (2) @(negedge core_clk);
        chk("frozen limit code", 12'h003, {7'h0, limit_code_eff});
        ce = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("limit code", 12'h009, {7'h0, limit_code_eff});
        rchk(8'h2e, 8'h01);
    endtask
    // Mid-run reset: cold start back on resistors, frequency code taken again
    task automatic t_reset();
        host_u.wr(8'h46, 8'h05);
        host_u.wr(8'h47, 8'h05);
        pin_code = 5'h04;
        rstn     = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        rchk(8'h2f, 8'h04);
        rchk(8'h46, 8'h00);
        chk("limit from reg", 12'h000, {11'h0, limit_from_reg});
        chk("freq from reg", 12'h000, {11'h0, freq_from_reg});
        chk("freq code", 12'h004, {7'h0, freq_code_eff});
        chk("limit code", {7'h0, res_code}, {7'h0, limit_code_eff});
    endtask
    // Verdict and end of run
    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        t_power_on();
        t_config();
        t_status();
        t_freeze();
        t_reset();
        summarize();
    end
    // Watchdog at 3000 cycles, well beyond the fewer than one hundred cycles needed
    initial begin
        #(40 * 3000);
        n_mismatch++;
        summarize();
    end
endmodule
